// ===== pvic_pkg.sv
package pvic_pkg;
    localparam int unsigned NUM_SRC = 154;
    localparam int unsigned PRIO_W = 8;
    localparam int unsigned PRIO_BITS = 3;
    localparam int unsigned EVT_W = 2;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_GROUP = 12'h004;
    localparam logic [11:0] OFS_THRESH = 12'h008;
    localparam logic [11:0] OFS_SEL = 12'h00C;
    localparam logic [11:0] OFS_SRC_CMD = 12'h010;
    localparam logic [11:0] OFS_SRC_PRIO = 12'h014;
    localparam logic [11:0] OFS_VTBASE = 12'h018;
    localparam logic [11:0] OFS_EVT_STAT = 12'h01C;
    localparam logic [11:0] OFS_EVT_MASK = 12'h020;
    localparam logic [11:0] OFS_RUNINFO = 12'h024;
    localparam int unsigned CMD_EN = 0;
    localparam int unsigned CMD_DIS = 1;
    localparam int unsigned CMD_PSET = 2;
    localparam int unsigned CMD_PCLR = 3;
    localparam int unsigned CMD_TRIG = 4;
    localparam int unsigned CTRL_GATE = 0;
    localparam int unsigned CTRL_PREV = 1;
    localparam int unsigned EVT_DISPATCH = 0;
    localparam int unsigned EVT_DONE = 1;
    localparam int unsigned VT_ALIGN = 10;
    localparam logic [7:0] VEC_FIRST = 8'h10;
    localparam logic [2:0] GROUP_RST = 3'h7;
    localparam logic [7:0] THRESH_RST = 8'h00;
    localparam logic [7:0] PRIO_RST = 8'h00;
    localparam logic [31:0] VTBASE_RST = 32'h0000_0000;
    localparam logic GATE_RST = 1'b0;
    localparam logic [3:0] GRP_IDLE = 4'h8;
endpackage

// ===== pvic_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pvic_ctrl
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pvic_pkg::NUM_SRC-1:0] irq_src,
    input wire logic irq_ack,
    input wire logic irq_eoi,
    input wire logic [7:0] irq_eoi_num,
    output logic irq_req,
    output logic [7:0] irq_num,
    output logic [31:0] irq_vector,
    output logic evt_irq
);
    localparam int unsigned N = pvic_pkg::NUM_SRC;
    localparam int unsigned EVT_W_T = pvic_pkg::EVT_W;

    function automatic logic [2:0] prio_top(input logic [7:0] p);
        return p[pvic_pkg::PRIO_W-1 -: pvic_pkg::PRIO_BITS];
    endfunction

    function automatic logic [2:0] grp_mask(input logic [2:0] g);
        case (g)
            3'h0: return 3'h0;
            3'h1: return 3'h4;
            3'h2: return 3'h6;
            default: return 3'h7;
        endcase
    endfunction

    function automatic logic [N-1:0] onehot(input logic [7:0] n);
        return {{(N-1){1'b0}}, 1'b1} << n;
    endfunction

    logic gate_open;
    logic gate_prev_closed;
    logic [2:0] group_val;
    logic [7:0] thresh;
    logic [7:0] src_sel;
    logic [31:0] vt_base;
    logic [EVT_W_T-1:0] evt_stat;
    logic [EVT_W_T-1:0] evt_mask;
    logic [N-1:0] src_enable;
    logic [N-1:0] src_pending;
    logic [N-1:0] src_active;
    logic [N-1:0] src_line_q;
    logic [7:0] src_prio [N];

    logic wr_go;
    logic setup;
    logic sel_ok;
    logic cmd_wr;
    logic ack_go;
    logic eoi_go;
    logic [2:0] pmask;
    logic thr_on;
    logic [N-1:0] set_vec;
    logic [N-1:0] clr_vec;
    logic [N-1:0] elig;
    logic win_valid;
    logic [7:0] win_num;
    logic [2:0] win_prio;
    logic [3:0] win_grp;
    logic [3:0] run_grp;
    logic dispatch_ok;
    logic [31:0] rd_data;
    logic rd_err;

    assign setup = psel && !penable;
    assign wr_go = psel && penable && pready && pwrite;
    assign sel_ok = src_sel < 8'(N);
    assign cmd_wr = wr_go && paddr == pvic_pkg::OFS_SRC_CMD && sel_ok;
    assign ack_go = irq_ack && irq_req;
    assign eoi_go = irq_eoi && irq_eoi_num < 8'(N);
    assign pmask = grp_mask(group_val);
    assign thr_on = prio_top(thresh) != 3'h0;

    // edge detect so a held line is serviced once per assertion
    always_comb
    begin
        set_vec = irq_src & ~src_line_q;
        clr_vec = '0;
        if (cmd_wr && (pwdata[pvic_pkg::CMD_PSET] || pwdata[pvic_pkg::CMD_TRIG]))
        begin
            set_vec = set_vec | onehot(src_sel);
        end
        if (cmd_wr && pwdata[pvic_pkg::CMD_PCLR])
        begin
            clr_vec = onehot(src_sel);
        end
        if (ack_go)
        begin
            clr_vec = clr_vec | onehot(irq_num);
        end
    end

    // full scan of all sources; strict compare keeps the lowest number on ties
    always_comb
    begin
        win_valid = 1'b0;
        win_num = 8'h00;
        win_prio = 3'h7;
        run_grp = pvic_pkg::GRP_IDLE;
        elig = '0;
        for (int i = 0; i < N; i++)
        begin
            if (src_active[i] && {1'b0, prio_top(src_prio[i]) & pmask} < run_grp)
            begin
                run_grp = {1'b0, prio_top(src_prio[i]) & pmask};
            end
            elig[i] = src_pending[i] && src_enable[i] && !src_active[i]
                && (!thr_on || prio_top(src_prio[i]) < prio_top(thresh));
            if (elig[i] && (!win_valid || prio_top(src_prio[i]) < win_prio))
            begin
                win_valid = 1'b1;
                win_num = 8'(i);
                win_prio = prio_top(src_prio[i]);
            end
        end
        win_grp = {1'b0, win_prio & pmask};
    end

    // only a strictly better preempt group interrupts a running handler
    assign dispatch_ok = win_valid && gate_open && win_grp < run_grp;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            irq_req <= 1'b0;
            irq_num <= 8'h00;
            irq_vector <= pvic_pkg::VTBASE_RST;
        end
        else
        begin
            irq_req <= dispatch_ok && !ack_go;
            irq_num <= win_num;
            irq_vector <= {vt_base[31:pvic_pkg::VT_ALIGN], 10'h000}
                + {22'h000000, 8'(win_num + pvic_pkg::VEC_FIRST), 2'b00};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            src_line_q <= '0;
            src_pending <= '0;
        end
        else
        begin
            src_line_q <= irq_src;
            src_pending <= (src_pending & ~clr_vec) | set_vec;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            src_active <= '0;
        end
        else
        begin
            src_active <= (src_active & ~(eoi_go ? onehot(irq_eoi_num) : '0))
                | (ack_go ? onehot(irq_num) : '0);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            src_enable <= '0;
        end
        else if (cmd_wr)
        begin
            if (pwdata[pvic_pkg::CMD_DIS])
            begin
                src_enable[src_sel] <= 1'b0;
            end
            if (pwdata[pvic_pkg::CMD_EN])
            begin
                src_enable[src_sel] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < N; i++)
            begin
                src_prio[i] <= pvic_pkg::PRIO_RST;
            end
        end
        else if (wr_go && paddr == pvic_pkg::OFS_SRC_PRIO && sel_ok)
        begin
            src_prio[src_sel] <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            gate_open <= pvic_pkg::GATE_RST;
            gate_prev_closed <= !pvic_pkg::GATE_RST;
        end
        else if (wr_go && paddr == pvic_pkg::OFS_CTRL)
        begin
            gate_open <= pwdata[pvic_pkg::CTRL_GATE];
            gate_prev_closed <= !gate_open;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            group_val <= pvic_pkg::GROUP_RST;
            thresh <= pvic_pkg::THRESH_RST;
            src_sel <= 8'h00;
            vt_base <= pvic_pkg::VTBASE_RST;
            evt_mask <= '0;
        end
        else if (wr_go)
        begin
            case (paddr)
                pvic_pkg::OFS_GROUP: group_val <= pwdata[2:0];
                pvic_pkg::OFS_THRESH: thresh <= pwdata[7:0];
                pvic_pkg::OFS_SEL: src_sel <= pwdata[7:0];
                pvic_pkg::OFS_VTBASE: vt_base <= {pwdata[31:10], 10'h000};
                pvic_pkg::OFS_EVT_MASK: evt_mask <= pwdata[EVT_W_T-1:0];
                default: ;
            endcase
        end
    end

    // new events win over a write-one-to-clear in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            evt_stat <= '0;
            evt_irq <= 1'b0;
        end
        else
        begin
            evt_stat <= (evt_stat & ~((wr_go && paddr == pvic_pkg::OFS_EVT_STAT)
                ? pwdata[EVT_W_T-1:0] : '0)) | {eoi_go, ack_go};
            evt_irq <= |(evt_stat & evt_mask);
        end
    end

    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            pvic_pkg::OFS_CTRL: rd_data = {30'h0, gate_prev_closed, gate_open};
            pvic_pkg::OFS_GROUP: rd_data = {29'h0, group_val};
            pvic_pkg::OFS_THRESH: rd_data = {24'h0, thresh};
            pvic_pkg::OFS_SEL: rd_data = {24'h0, src_sel};
            pvic_pkg::OFS_SRC_CMD:
                if (sel_ok)
                begin
                    rd_data = {29'h0, src_active[src_sel], src_pending[src_sel],
                        src_enable[src_sel]};
                end
            pvic_pkg::OFS_SRC_PRIO:
                rd_data = sel_ok ? {24'h0, src_prio[src_sel]} : 32'hFFFF_FFFF;
            pvic_pkg::OFS_VTBASE: rd_data = vt_base;
            pvic_pkg::OFS_EVT_STAT: rd_data = {30'h0, evt_stat};
            pvic_pkg::OFS_EVT_MASK: rd_data = {30'h0, evt_mask};
            pvic_pkg::OFS_RUNINFO: rd_data = {19'h0, run_grp, irq_req, irq_num};
            default: rd_err = 1'b1;
        endcase
    end

    // zero wait states: every access phase completes in one cycle
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && rd_err;
            if (setup && !pwrite)
            begin
                prdata <= rd_data;
            end
        end
    end

    property p_gate_blocks;
        @(posedge sys_clk) disable iff (!rst_b)
        !gate_open |=> !irq_req;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("request passed closed gate");
    property p_prev_gate;
        @(posedge sys_clk) disable iff (!rst_b)
        wr_go && paddr == pvic_pkg::OFS_CTRL |=> gate_prev_closed == !$past(gate_open);
    endproperty
    a_prev_gate: assert property (p_prev_gate) else $error("previous gate lost");
    property p_pend_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        cmd_wr && pwdata[pvic_pkg::CMD_PCLR] && !set_vec[src_sel]
            |=> !src_pending[$past(src_sel)];
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared");
    property p_win_enabled;
        @(posedge sys_clk) disable iff (!rst_b)
        win_valid |-> src_enable[win_num] && src_pending[win_num];
    endproperty
    a_win_enabled: assert property (p_win_enabled) else $error("disabled source won");
    property p_threshold;
        @(posedge sys_clk) disable iff (!rst_b)
        win_valid && thr_on |-> win_prio < prio_top(thresh);
    endproperty
    a_threshold: assert property (p_threshold) else $error("masked level passed");
    property p_low_num_tie;
        @(posedge sys_clk) disable iff (!rst_b)
        elig[0] && win_valid |-> win_num == 8'h00 || win_prio < prio_top(src_prio[0]);
    endproperty
    a_low_num_tie: assert property (p_low_num_tie) else $error("tie order broken");
    property p_no_equal_preempt;
        @(posedge sys_clk) disable iff (!rst_b)
        win_valid && win_grp >= run_grp |=> !irq_req;
    endproperty
    a_no_equal_preempt: assert property (p_no_equal_preempt) else $error("equal group preempted");
    property p_ack_active;
        @(posedge sys_clk) disable iff (!rst_b)
        ack_go && !eoi_go |=> src_active[$past(irq_num)] ##1 !irq_req || irq_num != $past(irq_num, 2);
    endproperty
    a_ack_active: assert property (p_ack_active) else $error("dispatch not tracked");
    property p_vector;
        @(posedge sys_clk) disable iff (!rst_b)
        irq_req |-> irq_vector[9:2] == 8'(irq_num + pvic_pkg::VEC_FIRST);
    endproperty
    a_vector: assert property (p_vector) else $error("vector entry wrong");
    property p_group_sat;
        @(posedge sys_clk) disable iff (!rst_b)
        group_val >= 3'h3 |-> pmask == 3'h7;
    endproperty
    a_group_sat: assert property (p_group_sat) else $error("grouping not saturated");

    c_preempt: cover property (@(posedge sys_clk) disable iff (!rst_b)
        ack_go && src_active != '0);
    c_tail_chain: cover property (@(posedge sys_clk) disable iff (!rst_b)
        eoi_go ##1 irq_req);
    c_thr_block: cover property (@(posedge sys_clk) disable iff (!rst_b)
        thr_on && src_pending != '0 && !win_valid);
endmodule
`default_nettype wire

// ===== pvic_core_mdl.sv
`timescale 1ns/1ps
`default_nettype none
module pvic_core_mdl
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic irq_req,
    input wire logic [7:0] irq_num,
    input wire logic [31:0] irq_vector,
    input wire logic [7:0] hold,
    output logic irq_ack,
    output logic irq_eoi,
    output logic [7:0] irq_eoi_num,
    output logic took,
    output logic [39:0] took_info
);
    logic [7:0] stk [8];
    logic [3:0] sp;
    logic [7:0] cnt;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            irq_ack <= 1'b0;
            irq_eoi <= 1'b0;
            irq_eoi_num <= 8'h00;
            took <= 1'b0;
            sp <= 4'h0;
            cnt <= 8'h00;
        end
        else
        begin
            // ack is counted only if the request still stands at that edge
            irq_ack <= irq_req && !irq_ack;
            took <= irq_ack && irq_req;
            irq_eoi <= 1'b0;
            // number is meaningless outside the pulse, so keep it moving
            irq_eoi_num <= ~irq_eoi_num;
            if (irq_ack && irq_req)
            begin
                took_info <= {irq_num, irq_vector};
                stk[sp[2:0]] <= irq_num;
                sp <= sp + 4'h1;
                cnt <= hold;
            end
            else if (sp != 4'h0 && !irq_ack)
            begin
                if (cnt == 8'h00)
                begin
                    irq_eoi <= 1'b1;
                    irq_eoi_num <= stk[3'(sp - 4'h1)];
                    sp <= sp - 4'h1;
                    cnt <= hold;
                end
                else
                    cnt <= cnt - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ===== pvic_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module pvic_ctrl_tb;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [pvic_pkg::NUM_SRC-1:0] irq_src = '0;
    logic irq_ack, irq_eoi, irq_req, evt_irq, took;
    logic [7:0] irq_eoi_num, irq_num;
    logic [31:0] irq_vector, vtb;
    logic [39:0] took_info, de;
    logic [7:0] hold = 8'h00;
    logic [7:0] s [4];
    logic [7:0] p [4];
    logic [3:0] used;
    logic [32:0] qr [$];
    logic [39:0] qd [$];
    logic [32:0] re;
    int err_total = 0;
    int n_tests = 0;
    int i, k, b;
    always #2.5 sys_clk = ~sys_clk;
    pvic_ctrl DUT (.sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_src(irq_src), .irq_ack(irq_ack), .irq_eoi(irq_eoi),
        .irq_eoi_num(irq_eoi_num), .irq_req(irq_req), .irq_num(irq_num),
        .irq_vector(irq_vector), .evt_irq(evt_irq));
    pvic_core_mdl core (.sys_clk(sys_clk), .rst_b(rst_b), .irq_req(irq_req),
        .irq_num(irq_num), .irq_vector(irq_vector), .hold(hold),
        .irq_ack(irq_ack), .irq_eoi(irq_eoi), .irq_eoi_num(irq_eoi_num),
        .took(took), .took_info(took_info));
    task automatic stop_test();
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic [11:0] a, input logic w, logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        qr.push_back(e);
        apb(a, 1'b0, 32'h0000_0000);
    endtask
    task automatic cfg(input logic [7:0] sn, pr, input logic [4:0] cmd);
        wr(pvic_pkg::OFS_SEL, {24'h000000, sn});
        wr(pvic_pkg::OFS_SRC_PRIO, {24'h000000, pr});
        rd(pvic_pkg::OFS_SRC_PRIO, {25'h0000000, pr});
        wr(pvic_pkg::OFS_SRC_CMD, {27'h0000000, cmd});
    endtask
    task automatic drain();
        for (int j = 0; j < 3000 && qd.size() > 0; j++)
            @(posedge sys_clk);
        repeat (30) @(posedge sys_clk);
        `CHK("dispatch left", 32'h0, 32'(qd.size()))
    endtask
    function automatic logic [39:0] dsp(input logic [7:0] n);
        return {n, {vtb[31:10], 10'h000} + 32'(4 * (n + pvic_pkg::VEC_FIRST))};
    endfunction
    always @(posedge sys_clk)
    begin
        if (psel && penable && pready && !pwrite && qr.size() > 0)
        begin
            re = qr.pop_front();
            `CHK("read", re, {pslverr, prdata})
        end
        if (took)
        begin
            de = (qd.size() > 0) ? qd.pop_front() : 'x;
            `CHK("dispatch", de, took_info)
        end
    end
    initial
    begin
        #100000;
        err_total++;
        stop_test();
    end
    initial
    begin
        void'($urandom(52));
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(pvic_pkg::OFS_CTRL, 33'h2);
        rd(pvic_pkg::OFS_GROUP, 33'h7);
        rd(pvic_pkg::OFS_THRESH, 33'h0);
        rd(12'h0FC, 33'h1_0000_0000);
        // table kept on a 1 kB boundary
        vtb = $urandom() & 32'hFFFF_FC00;
        wr(pvic_pkg::OFS_VTBASE, vtb);
        wr(pvic_pkg::OFS_EVT_MASK, 32'h0000_0001);
        for (i = 0; i < 4; i++)
        begin
            s[i] = 8'(i * 38 + $urandom_range(37, 0));
            p[i] = 8'($urandom());
        end
        s[0] = 8'h00;
        // equal upper bits, random lower bits: tie goes by number
        p[1] = {p[0][7:5], 5'($urandom())};
        cfg(s[0], p[0], 5'h01);
        irq_src[s[0]] <= 1'b1;
        cfg(s[1], p[1], 5'h05);
        cfg(s[2], p[2], 5'h11);
        cfg(s[3], p[3], 5'h05);
        irq_src[s[0]] <= 1'b0;
        rd(pvic_pkg::OFS_SRC_CMD, 33'h3);
        used = 4'h0;
        for (k = 0; k < 4; k++)
        begin
            b = -1;
            for (i = 0; i < 4; i++)
                if (!used[i] && (b < 0 ||
                    {p[i][7:5], s[i]} < {p[b][7:5], s[b]}))
                    b = i;
            used[b] = 1'b1;
            qd.push_back(dsp(s[b]));
        end
        hold <= 8'h06;
        wr(pvic_pkg::OFS_CTRL, 32'h0000_0001);
        rd(pvic_pkg::OFS_CTRL, 33'h3);
        drain();
        `CHK("evt_irq", 1'b1, evt_irq)
        wr(pvic_pkg::OFS_EVT_STAT, 32'h0000_0003);
        repeat (3) @(posedge sys_clk);
        `CHK("evt_irq", 1'b0, evt_irq)
        wr(pvic_pkg::OFS_THRESH, 32'h0000_0080);
        qd.push_back(dsp(8'h0B));
        cfg(8'h0A, 8'h80, 5'h05);
        cfg(8'h0B, 8'h7F, 5'h05);
        drain();
        qd.push_back(dsp(8'h0A));
        wr(pvic_pkg::OFS_THRESH, 32'h0000_0000);
        drain();
        // sub bits only: better source tail-chains; full split: it preempts
        hold <= 8'h40;
        for (k = 0; k < 2; k++)
        begin
            wr(pvic_pkg::OFS_GROUP, (k == 0) ? 32'h0000_0001 : 32'h0000_0003);
            rd(pvic_pkg::OFS_GROUP, (k == 0) ? 33'h1 : 33'h3);
            cfg(8'h31, 8'h00, 5'h01);
            qd.push_back(dsp(8'h30));
            qd.push_back(dsp(8'h31));
            cfg(8'h30, 8'h20, 5'h11);
            wr(pvic_pkg::OFS_SEL, 32'h0000_0031);
            wr(pvic_pkg::OFS_SRC_CMD, 32'h0000_0010);
            repeat (6) @(posedge sys_clk);
            rd(pvic_pkg::OFS_SRC_CMD, (k == 0) ? 33'h3 : 33'h5);
            drain();
            // both handlers must have ended before the next round
            repeat (150) @(posedge sys_clk);
        end
        hold <= 8'h06;
        cfg(8'h14, 8'h00, 5'h06);
        repeat (20) @(posedge sys_clk);
        rd(pvic_pkg::OFS_SRC_CMD, 33'h2);
        wr(pvic_pkg::OFS_SRC_CMD, 32'h0000_0008);
        rd(pvic_pkg::OFS_SRC_CMD, 33'h0);
        wr(pvic_pkg::OFS_SRC_CMD, 32'h0000_0001);
        drain();
        wr(pvic_pkg::OFS_CTRL, 32'h0000_0000);
        rd(pvic_pkg::OFS_CTRL, 33'h0);
        rd(pvic_pkg::OFS_SRC_CMD, 33'h1);
        // let the checker see the last access edge
        repeat (2) @(posedge sys_clk);
        stop_test();
    end
endmodule
`default_nettype wire
